// File: core/rsbw_pkg.sv
// shared constants and types for the slow buffered remote write block
package rsbw_pkg;

  // apb register byte offsets
  localparam logic [7:0] RSBW_OFS_DEVICE_CONFIG = 8'h00;  // wait counts
  localparam logic [7:0] RSBW_OFS_REMOTE_CONFIG = 8'h04;  // memory select, lockout
  localparam logic [7:0] RSBW_OFS_STATUS = 8'h08;  // fsm state, flags
  localparam logic [7:0] RSBW_OFS_PROGRAM_COUNTER = 8'h0C;  // program counter
  localparam logic [7:0] RSBW_OFS_INSTR_WORD = 8'h10;  // last assembled word

  // device config field positions
  localparam int RSBW_DW_LSB = 0;  // data wait count, 3 bits
  localparam int RSBW_IW_LSB = 3;  // instruction wait count, 2 bits
  // remote config field positions
  localparam int RSBW_MS_LSB = 0;  // memory select, 2 bits
  localparam int RSBW_LOR_BIT = 2;  // remote lockout
  // status field positions
  localparam int RSBW_ST_STATE_LSB = 0;  // fsm state, 4 bits
  localparam int RSBW_ST_HIB_BIT = 4;  // high byte pending
  localparam int RSBW_ST_PEND_BIT = 5;  // config change pending
  localparam int RSBW_ST_INSTR_LOW_HOLDING_LSB = 8;  // low holding byte

  // reset values
  localparam logic [2:0] RSBW_RST_DATA_WAIT = 3'h0;  // no data waits
  localparam logic [1:0] RSBW_RST_INSTR_WAIT = 2'h0;  // no instruction waits
  localparam logic [1:0] RSBW_RST_MEM_SELECT = 2'h0;  // data memory
  localparam logic RSBW_RST_LOCKOUT = 1'b0;  // remote allowed
  localparam logic [15:0] RSBW_RST_PC = 16'h0000;  // program counter

  // memory select encodings
  localparam logic [1:0] RSBW_MS_DATA = 2'h0;  // data memory
  localparam logic [1:0] RSBW_MS_INSTR = 2'h1;  // instruction memory
  localparam logic [1:0] RSBW_MS_PC_LOW = 2'h2;  // program counter low
  localparam logic [1:0] RSBW_MS_PC_HIGH = 2'h3;  // program counter high

  // remote access machine states
  typedef enum logic [3:0] {
    RSBW_IDLE1, RSBW_IDLE2, RSBW_IDLE3, RSBW_STB, RSBW_STC,
    RSBW_D_RIC, RSBW_D_PCL, RSBW_D_PCH, RSBW_D_DATA_MEMORY, RSBW_D_ILO, RSBW_D_IHI,
    RSBW_ST_E, RSBW_ST_F
  } rsbw_state_type;

endpackage

// File: core/rsbw_remote_write.sv
// remote access machine, slow buffered write path, with apb registers
`timescale 1ns/1ps

module rsbw_remote_write
  import rsbw_pkg::*;
(
  input wire logic CLK_SYS,  // system clock, 125 MHz
  input wire logic RSTN,  // sync reset, active low
  // apb slave
  input wire logic PSEL,  // apb select
  input wire logic PENABLE,  // apb access phase
  input wire logic PWRITE,  // apb direction
  input wire logic [7:0] PADDR,  // apb byte address
  input wire logic [31:0] PWDATA,  // apb write data
  output logic [31:0] PRDATA,  // apb read data
  output logic PREADY,  // apb ready
  output logic PSLVERR,  // apb error, unmapped
  // remote host pins
  input wire logic REMOTE_ACCESS_ENABLE,  // host access enable, high
  input wire logic REMOTE_WRITE_STROBE_N,  // host write strobe, low
  input wire logic COMMAND_SELECT,  // high targets config register
  input wire logic WAIT_N,  // external wait, low extends
  input wire logic LOCK_N,  // external lock, high lets local in
  input wire logic [7:0] AD_IN,  // multiplexed bus, input side
  output logic [7:0] AD_OUT,  // multiplexed bus, output side
  output logic AD_OE,  // device drives multiplexed bus
  output logic ADDR_OE,  // device drives address bus
  output logic TRANSFER_ACKNOWLEDGE,  // low holds the host
  output logic LOCAL_BUS_OWNER_N,  // high while host owns buses
  output logic DATA_WRITE_N,  // data memory write strobe
  output logic INSTR_MEM_WRITE_STROBE_N,  // instruction write strobe
  output logic [15:0] INSTR_WORD,  // assembled instruction word
  output logic [15:0] PROGRAM_COUNTER,  // program counter
  // timing control unit
  input wire logic LOCAL_BUS_REQUEST,  // local data memory request
  output logic LOCAL_BUS_GRANT,  // local access granted
  output logic LOCAL_WAIT  // holds cpu in remote wait
);

  // pin synchronisers, two stages each
  logic [12:0] pin_meta;  // first stage, read only by second
  logic [12:0] pin_sync;  // second stage
  logic enable_s;  // synced access enable
  logic strobe_n_s;  // synced write strobe
  logic cmd_s;  // synced command select
  logic wait_n_s;  // synced wait
  logic lock_n_s;  // synced lock
  logic [7:0] ad_s;  // synced bus data

  // machine and configuration state
  rsbw_state_type state;  // current state
  rsbw_state_type next_state;  // next state
  logic request;  // remote write request
  logic [2:0] data_wait_count;  // programmed data waits
  logic [1:0] instr_wait_count;  // programmed instruction waits
  logic [1:0] memory_select;  // active target select
  logic remote_lockout;  // active lockout
  logic [2:0] pend_config;  // remote written config, not yet live
  logic pend_valid;  // config change waiting
  logic high_byte_pending;  // next instruction byte is high
  logic [7:0] instr_low_holding;  // held low instruction byte
  logic instr_target;  // current access is instruction memory
  logic high_target;  // current access is the high byte
  logic data_done;  // data waits elapsed
  logic instr_done;  // instruction waits elapsed
  logic waits_done;  // waits of current target elapsed
  logic apb_access;  // apb access phase, not yet answered
  logic apb_wr_ric;  // apb write to remote config

  // two flop capture of all pin inputs
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      pin_meta <= 13'h1C00;
      pin_sync <= 13'h1C00;
    end else begin
      pin_meta <= {REMOTE_WRITE_STROBE_N, LOCK_N, WAIT_N, COMMAND_SELECT, REMOTE_ACCESS_ENABLE, AD_IN};
      pin_sync <= pin_meta;
    end
  end

  assign ad_s = pin_sync[7:0];
  assign enable_s = pin_sync[8];
  assign cmd_s = pin_sync[9];
  assign wait_n_s = pin_sync[10];
  assign lock_n_s = pin_sync[11];
  assign strobe_n_s = pin_sync[12];

  // request formed from enable and strobe
  // and of both pins
  assign request = enable_s & ~strobe_n_s;

  // waits counted for memory targets only, pc and config take none
  assign waits_done = (state == RSBW_D_DATA_MEMORY) ? data_done :
    ((state == RSBW_D_ILO || state == RSBW_D_IHI) ? instr_done : 1'b1);

  rsbw_wait_counter u_data_wait (
    .CLK_SYS(CLK_SYS),
    .RSTN(RSTN),
    .load(state == RSBW_STC),
    .load_value(data_wait_count),
    .run(state == RSBW_D_DATA_MEMORY),
    .done(data_done)
  );

  rsbw_wait_counter u_instr_wait (
    .CLK_SYS(CLK_SYS),
    .RSTN(RSTN),
    .load(state == RSBW_STC),
    .load_value({1'b0, instr_wait_count}),
    .run(state == RSBW_D_ILO || state == RSBW_D_IHI),
    .done(instr_done)
  );

  // next state of the remote access machine
  always_comb begin
    next_state = state;
    case (state)
      RSBW_IDLE1, RSBW_IDLE2, RSBW_IDLE3: begin
        if (!request) begin
          next_state = RSBW_IDLE1;
        // park while locked out or locally granted
        end else if (remote_lockout || LOCAL_BUS_GRANT) begin
          next_state = RSBW_IDLE2;
        end else if (!LOCAL_BUS_REQUEST) begin
          next_state = RSBW_STB;
        end else begin
          next_state = (state == RSBW_IDLE3) ? RSBW_IDLE1 : state;
        end
      end
      RSBW_STB: begin
        next_state = RSBW_STC;
      end
      RSBW_STC: begin
        if (cmd_s) begin
          next_state = RSBW_D_RIC;
        end else begin
          case (memory_select)
            RSBW_MS_PC_LOW: next_state = RSBW_D_PCL;
            RSBW_MS_PC_HIGH: next_state = RSBW_D_PCH;
            RSBW_MS_DATA: next_state = RSBW_D_DATA_MEMORY;
            default: next_state = high_byte_pending ? RSBW_D_IHI : RSBW_D_ILO;
          endcase
        end
      end
      RSBW_D_RIC, RSBW_D_PCL, RSBW_D_PCH, RSBW_D_DATA_MEMORY, RSBW_D_ILO, RSBW_D_IHI: begin
        // external wait stretches the D state
        if (waits_done && wait_n_s) begin
          next_state = RSBW_ST_E;
        end
      end
      RSBW_ST_E: begin
        // loop until the host lets go
        if (!request) begin
          next_state = RSBW_ST_F;
        end
      end
      RSBW_ST_F: begin
        // F always leads to idle three
        next_state = RSBW_IDLE3;
      end
      default: begin
        next_state = RSBW_IDLE1;
      end
    endcase
  end

  // state register
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      state <= RSBW_IDLE1;
    end else begin
      state <= next_state;
    end
  end

  // remembers target for the E and F states
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      instr_target <= 1'b0;
      high_target <= 1'b0;
    end else if (state == RSBW_STC) begin
      instr_target <= !cmd_s && memory_select == RSBW_MS_INSTR;
      high_target <= !cmd_s && memory_select == RSBW_MS_INSTR && high_byte_pending;
    end
  end

  // local bus grant and cpu wait
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      LOCAL_BUS_GRANT <= 1'b0;
      LOCAL_WAIT <= 1'b0;
    end else begin
      // grant in idle with lock high
      LOCAL_BUS_GRANT <= LOCAL_BUS_REQUEST && lock_n_s &&
        (next_state == RSBW_IDLE1 || next_state == RSBW_IDLE2 || next_state == RSBW_IDLE3);
      LOCAL_WAIT <= LOCAL_BUS_REQUEST &&
        !(next_state == RSBW_IDLE1 || next_state == RSBW_IDLE2 || next_state == RSBW_IDLE3);
    end
  end

  // acknowledge towards the host
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      TRANSFER_ACKNOWLEDGE <= 1'b1;
    end else if (next_state == RSBW_ST_E) begin
      TRANSFER_ACKNOWLEDGE <= request;
    end else begin
      // low as soon as request seen
      TRANSFER_ACKNOWLEDGE <= !request || next_state == RSBW_ST_F ||
        (next_state == RSBW_IDLE3) || (state == RSBW_ST_E);
    end
  end

  // bus ownership and drive enables
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      LOCAL_BUS_OWNER_N <= 1'b0;
      ADDR_OE <= 1'b1;
      AD_OE <= 1'b1;
    end else begin
      // owner high from C through F
      // owner low again in idle three
      LOCAL_BUS_OWNER_N <= next_state inside {RSBW_STC, RSBW_D_RIC, RSBW_D_PCL, RSBW_D_PCH,
        RSBW_D_DATA_MEMORY, RSBW_D_ILO, RSBW_D_IHI, RSBW_ST_E, RSBW_ST_F};
      // released on entering B, host data synced by D
      ADDR_OE <= next_state == RSBW_IDLE1 || next_state == RSBW_IDLE2;
      AD_OE <= next_state == RSBW_IDLE1 || next_state == RSBW_IDLE2;
    end
  end

  // memory write strobes
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      DATA_WRITE_N <= 1'b1;
      INSTR_MEM_WRITE_STROBE_N <= 1'b1;
    end else begin
      DATA_WRITE_N <= next_state != RSBW_D_DATA_MEMORY;
      // strobe from C on high byte
      // held through the high byte D state
      INSTR_MEM_WRITE_STROBE_N <= !((next_state == RSBW_STC && !cmd_s &&
        memory_select == RSBW_MS_INSTR && high_byte_pending) || next_state == RSBW_D_IHI);
    end
  end

  // instruction byte holding and word assembly
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      instr_low_holding <= 8'h00;
      INSTR_WORD <= 16'h0000;
    end else if (state == RSBW_D_ILO) begin
      instr_low_holding <= ad_s;
    end else if (state == RSBW_D_IHI) begin
      INSTR_WORD <= {ad_s, instr_low_holding};
    end
  end

  // high byte pending flag
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      high_byte_pending <= 1'b0;
    end else if (state == RSBW_ST_F && instr_target) begin
      high_byte_pending <= ~high_byte_pending;
    end else if ((apb_wr_ric && PWDATA[RSBW_MS_LSB +: 2] == RSBW_MS_INSTR) ||
                 (state == RSBW_IDLE3 && pend_valid && pend_config[1:0] == RSBW_MS_INSTR)) begin
      // select 01 write resets the boundary
      high_byte_pending <= 1'b0;
    end
  end

  // program counter
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      PROGRAM_COUNTER <= RSBW_RST_PC;
    end else if (state == RSBW_D_PCL) begin
      PROGRAM_COUNTER <= {PROGRAM_COUNTER[15:8], ad_s};
    end else if (state == RSBW_D_PCH) begin
      PROGRAM_COUNTER <= {ad_s, PROGRAM_COUNTER[7:0]};
    end else if (state == RSBW_ST_F && high_target) begin
      PROGRAM_COUNTER <= PROGRAM_COUNTER + 16'h0001;
    end
  end

  // remote config: remote writes pend, apb writes apply at once except in RSBW_D_RIC or the idle three apply cycle, where they are lost
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      memory_select <= RSBW_RST_MEM_SELECT;
      remote_lockout <= RSBW_RST_LOCKOUT;
      pend_config <= 3'h0;
      pend_valid <= 1'b0;
    end else if (state == RSBW_D_RIC) begin
      pend_config <= ad_s[2:0];
      pend_valid <= 1'b1;
    end else if (state == RSBW_IDLE3 && pend_valid) begin
      // mode change live one state later
      memory_select <= pend_config[1:0];
      remote_lockout <= pend_config[RSBW_LOR_BIT];
      pend_valid <= 1'b0;
    end else if (apb_wr_ric) begin
      memory_select <= PWDATA[RSBW_MS_LSB +: 2];
      remote_lockout <= PWDATA[RSBW_LOR_BIT];
    end
  end

  // device config written by software
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      data_wait_count <= RSBW_RST_DATA_WAIT;
      instr_wait_count <= RSBW_RST_INSTR_WAIT;
    end else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == RSBW_OFS_DEVICE_CONFIG) begin
      data_wait_count <= PWDATA[RSBW_DW_LSB +: 3];
      instr_wait_count <= PWDATA[RSBW_IW_LSB +: 2];
    end
  end

  // apb access phase decode, answered one cycle later
  assign apb_access = PSEL && PENABLE && !PREADY;
  // writes land at the edge where ready is seen high
  assign apb_wr_ric = PSEL && PENABLE && PREADY && PWRITE && PADDR == RSBW_OFS_REMOTE_CONFIG;

  // register read mux
  function automatic logic [31:0] read_reg(input logic [7:0] addr);
    logic [31:0] value;
    value = 32'h00000000;
    case (addr)
      RSBW_OFS_DEVICE_CONFIG: begin
        value[RSBW_DW_LSB +: 3] = data_wait_count;
        value[RSBW_IW_LSB +: 2] = instr_wait_count;
      end
      RSBW_OFS_REMOTE_CONFIG: begin
        value[RSBW_MS_LSB +: 2] = memory_select;
        value[RSBW_LOR_BIT] = remote_lockout;
      end
      RSBW_OFS_STATUS: begin
        value[RSBW_ST_STATE_LSB +: 4] = state;
        value[RSBW_ST_HIB_BIT] = high_byte_pending;
        value[RSBW_ST_PEND_BIT] = pend_valid;
        value[RSBW_ST_INSTR_LOW_HOLDING_LSB +: 8] = instr_low_holding;
      end
      RSBW_OFS_PROGRAM_COUNTER: value[15:0] = PROGRAM_COUNTER;
      RSBW_OFS_INSTR_WORD: value[15:0] = INSTR_WORD;
      default: value = 32'h00000000;
    endcase
    return value;
  endfunction

  // address is mapped
  function automatic logic is_mapped(input logic [7:0] addr);
    return addr == RSBW_OFS_DEVICE_CONFIG || addr == RSBW_OFS_REMOTE_CONFIG ||
      addr == RSBW_OFS_STATUS || addr == RSBW_OFS_PROGRAM_COUNTER || addr == RSBW_OFS_INSTR_WORD;
  endfunction

  // apb answer registers
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= apb_access;
      PSLVERR <= apb_access && !is_mapped(PADDR);
      PRDATA <= (apb_access && !PWRITE) ? read_reg(PADDR) : 32'h00000000;
    end
  end

  // multiplexed bus output: program counter low byte when driven
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      AD_OUT <= 8'h00;
    end else begin
      AD_OUT <= PROGRAM_COUNTER[7:0];
    end
  end

endmodule

// File: core/rsbw_wait_counter.sv
// loadable down counter for programmed memory wait states
`timescale 1ns/1ps
module rsbw_wait_counter
  import rsbw_pkg::*;
(
  input wire logic CLK_SYS,  // system clock
  input wire logic RSTN,  // sync reset, active low
  input wire logic load,  // load the count
  input wire logic [2:0] load_value,  // waits to insert
  input wire logic run,  // count down while high
  output logic done  // no waits left
);
  logic [2:0] count;  // waits remaining

  // load, then count down to zero
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      count <= 3'h0;
    end else if (load) begin
      count <= load_value;
    end else if (run && count != 3'h0) begin
      count <= count - 3'h1;
    end
  end

  // done once the count has run out
  assign done = (count == 3'h0);
endmodule

// File: dv/remote_slow_buffered_write_bench.sv
// self-checking bench for the slow buffered remote write block
`timescale 1ns/1ps
module remote_slow_buffered_write_bench;
  import rsbw_pkg::*;
  logic CLK_SYS, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, REMOTE_ACCESS_ENABLE, REMOTE_WRITE_STROBE_N;
  logic COMMAND_SELECT, WAIT_N, LOCK_N, AD_OE, ADDR_OE, TRANSFER_ACKNOWLEDGE, LOCAL_BUS_OWNER_N, DATA_WRITE_N;
  logic INSTR_MEM_WRITE_STROBE_N, LOCAL_BUS_REQUEST, LOCAL_BUS_GRANT, LOCAL_WAIT, go, cmd, done, e;
  logic [7:0] PADDR, AD_IN, AD_OUT, data, b0, b1;
  logic [31:0] PWDATA, PRDATA, r;
  logic [15:0] INSTR_WORD, PROGRAM_COUNTER;
  logic [3:0] stall;
  logic [2:0] dw;
  int error_cnt = 0, samples_checked = 0, dcnt = 0, icnt = 0;
  rsbw_remote_write rsbw_remote_write_i (.*);
  rsbw_host_model rsbw_host_model_i (.*);
  // clock, 8 ns period
  initial begin
    CLK_SYS = 0;
    forever #4 CLK_SYS = ~CLK_SYS;
  end
  // strobe cycle counters
  always @(posedge CLK_SYS) begin
    if (DATA_WRITE_N === 1'b0) dcnt++;
    if (INSTR_MEM_WRITE_STROBE_N === 1'b0) icnt++;
  end
  function automatic int dcyc(input logic [2:0] w);
    return 1 + w;
  endfunction
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    PSEL <= 1; PWRITE <= w; PADDR <= a; PWDATA <= d;
    @(posedge CLK_SYS) PENABLE <= 1;
    do @(posedge CLK_SYS); while (PREADY !== 1'b1);
    r = PRDATA; e = PSLVERR; PSEL <= 0; PENABLE <= 0;
    @(posedge CLK_SYS);
  endtask
  task automatic wait_sig(ref logic s, input logic v);
    while (s !== v) @(posedge CLK_SYS);
  endtask
  task automatic start(input logic c, input logic [7:0] d, input logic [3:0] s);
    cmd <= c; data <= d; stall <= s; go <= 1; dcnt = 0; icnt = 0;
    @(posedge CLK_SYS) go <= 0;
  endtask
  task automatic finish_wr;
    wait_sig(done, 1'b1);
    wait_sig(ADDR_OE, 1'b1);
    repeat (2) @(posedge CLK_SYS);
  endtask
  task automatic xfer(input logic c, input logic [7:0] d, input logic [3:0] s);
    start(c, d, s);
    finish_wr();
  endtask
  initial begin
    #200000 error_cnt++;
    end_of_test();
  end
  initial begin
    RSTN = 0; PSEL = 0; PENABLE = 0; PWRITE = 0; PADDR = 0; PWDATA = 0; LOCK_N = 1;
    LOCAL_BUS_REQUEST = 0; go = 0; cmd = 0; data = 0; stall = 0;
    void'($urandom(3557));
    repeat (12) @(posedge CLK_SYS);
    RSTN <= 1;
    repeat (3) @(posedge CLK_SYS);
    chk(TRANSFER_ACKNOWLEDGE === 1'b1 && LOCAL_BUS_OWNER_N === 1'b0, "idle outputs");
    for (int a = 0; a <= 16; a += 4) begin
      apb(0, a[7:0], 0);
      chk(r === 32'h0 && e === 1'b0, "reset value");
    end
    apb(1, RSBW_OFS_STATUS, 32'hFFFF);
    apb(0, RSBW_OFS_STATUS, 0);
    chk(r === 32'h0, "status read only");
    apb(0, 8'h40, 0);
    chk(e === 1'b1 && r === 32'h0, "unmapped error");
    // random data memory writes with waits
    repeat (6) begin
      dw = $urandom % 8; stall = $urandom % 4;
      apb(1, RSBW_OFS_DEVICE_CONFIG, {29'h0, dw});
      xfer(0, $urandom, stall);
      chk(stall == 0 ? dcnt == dcyc(dw) : dcnt >= dcyc(dw), "data wait count");
    end
    // program counter bytes
    b0 = $urandom; b1 = $urandom;
    apb(1, RSBW_OFS_REMOTE_CONFIG, {30'h0, RSBW_MS_PC_LOW});
    xfer(0, b0, 0);
    apb(1, RSBW_OFS_REMOTE_CONFIG, {30'h0, RSBW_MS_PC_HIGH});
    xfer(0, b1, 0);
    chk(PROGRAM_COUNTER === {b1, b0} && AD_OUT === b0, "pc bytes");
    // instruction word assembly, flag cleared by select write
    apb(1, RSBW_OFS_REMOTE_CONFIG, {30'h0, RSBW_MS_INSTR});
    xfer(0, 8'h5A, 0);
    chk(icnt == 0, "no strobe on low byte");
    xfer(0, 8'hC3, 0);
    chk(INSTR_WORD === 16'hC35A && icnt > 0, "instruction word");
    chk(PROGRAM_COUNTER === {b1, b0} + 16'h1, "pc increment");
    // config register written by the host
    xfer(1, {6'h0, RSBW_MS_PC_LOW}, 0);
    apb(0, RSBW_OFS_REMOTE_CONFIG, 0);
    chk(r[1:0] === RSBW_MS_PC_LOW, "host config write");
    xfer(0, 8'hA7, 0);
    chk(PROGRAM_COUNTER[7:0] === 8'hA7, "new mode used");
    // lockout parks the request
    apb(1, RSBW_OFS_REMOTE_CONFIG, 32'h4);
    start(0, 8'h11, 0);
    repeat (20) @(posedge CLK_SYS);
    chk(TRANSFER_ACKNOWLEDGE === 1'b0 && LOCAL_BUS_OWNER_N === 1'b0, "lockout holds");
    apb(1, RSBW_OFS_REMOTE_CONFIG, 32'h0);
    finish_wr();
    chk(dcnt > 0, "released write done");
    // local grants with lock high and low
    LOCAL_BUS_REQUEST <= 1;
    repeat (5) @(posedge CLK_SYS);
    chk(LOCAL_BUS_GRANT === 1'b1, "local grant");
    LOCAL_BUS_REQUEST <= 0; LOCK_N <= 0;
    repeat (5) @(posedge CLK_SYS);
    LOCAL_BUS_REQUEST <= 1;
    repeat (5) @(posedge CLK_SYS);
    chk(LOCAL_BUS_GRANT === 1'b0, "lock blocks grant");
    LOCAL_BUS_REQUEST <= 0; LOCK_N <= 1;
    // local request during remote access is held
    apb(1, RSBW_OFS_DEVICE_CONFIG, 32'h7);
    start(0, 8'h3C, 0);
    wait_sig(LOCAL_BUS_OWNER_N, 1'b1);
    LOCAL_BUS_REQUEST <= 1;
    repeat (3) @(posedge CLK_SYS);
    chk(LOCAL_WAIT === 1'b1 && LOCAL_BUS_GRANT === 1'b0, "local waited");
    LOCAL_BUS_REQUEST <= 0;
    finish_wr();
    chk(dcnt == dcyc(3'h7), "max data waits");
    end_of_test();
  end
endmodule

// File: dv/rsbw_checker.sv
// concurrent checks on the remote write block ports
`timescale 1ns/1ps
module rsbw_checker (
  input wire logic CLK_SYS,  // system clock
  input wire logic RSTN,  // sync reset, active low
  input wire logic PSEL,  // apb select
  input wire logic PENABLE,  // apb access phase
  input wire logic PREADY,  // apb ready
  input wire logic REMOTE_ACCESS_ENABLE,  // host enable
  input wire logic REMOTE_WRITE_STROBE_N,  // host strobe
  input wire logic WAIT_N,  // external wait
  input wire logic ADDR_OE,  // address bus drive
  input wire logic AD_OE,  // data bus drive
  input wire logic TRANSFER_ACKNOWLEDGE,  // host hold
  input wire logic LOCAL_BUS_OWNER_N,  // host owns buses
  input wire logic DATA_WRITE_N,  // data strobe
  input wire logic INSTR_MEM_WRITE_STROBE_N,  // instruction strobe
  input wire logic [15:0] PROGRAM_COUNTER,  // program counter
  input wire logic LOCAL_BUS_GRANT  // local grant
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  // idle keeps acknowledge high
  idle_no_ack_a: assert property ((!REMOTE_ACCESS_ENABLE)[*4] |-> TRANSFER_ACKNOWLEDGE && DATA_WRITE_N)
    else $error("ack or strobe active while idle");
  ack_on_request_a: assert property ($fell(TRANSFER_ACKNOWLEDGE) |->
    $past(REMOTE_ACCESS_ENABLE, 3) && !$past(REMOTE_WRITE_STROBE_N, 3)) else $error("ack fell without request");
  owner_takes_a: assert property ($rose(LOCAL_BUS_OWNER_N) |-> !TRANSFER_ACKNOWLEDGE && !ADDR_OE)
    else $error("owner rose with ack high or bus driven");
  no_grant_a: assert property (LOCAL_BUS_OWNER_N |-> !LOCAL_BUS_GRANT)
    else $error("local grant while host owns buses");
  data_strobe_a: assert property (!DATA_WRITE_N |-> LOCAL_BUS_OWNER_N && !AD_OE && !TRANSFER_ACKNOWLEDGE)
    else $error("data strobe outside owned access");
  wait_extends_a: assert property ((!DATA_WRITE_N && !WAIT_N)[*3] |=> !DATA_WRITE_N)
    else $error("data access ended while wait low");
  hold_after_ack_a: assert property ($rose(TRANSFER_ACKNOWLEDGE) && LOCAL_BUS_OWNER_N |=> LOCAL_BUS_OWNER_N[*2])
    else $error("owner dropped too soon after ack");
  owner_release_a: assert property ($fell(LOCAL_BUS_OWNER_N) |-> !ADDR_OE ##1 ADDR_OE)
    else $error("bus not released one cycle after owner drop");
  instr_strobe_a: assert property (!INSTR_MEM_WRITE_STROBE_N |-> LOCAL_BUS_OWNER_N && !TRANSFER_ACKNOWLEDGE)
    else $error("instruction strobe outside access");
  pc_change_a: assert property ($changed(PROGRAM_COUNTER) |-> $past(LOCAL_BUS_OWNER_N) || !$past(RSTN))
    else $error("program counter changed outside access");
  apb_ready_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("apb ready late");
endmodule
bind rsbw_remote_write rsbw_checker rsbw_checker_i (.CLK_SYS, .RSTN, .PSEL, .PENABLE, .PREADY,
  .REMOTE_ACCESS_ENABLE, .REMOTE_WRITE_STROBE_N, .WAIT_N, .ADDR_OE, .AD_OE, .TRANSFER_ACKNOWLEDGE,
  .LOCAL_BUS_OWNER_N, .DATA_WRITE_N, .INSTR_MEM_WRITE_STROBE_N, .PROGRAM_COUNTER, .LOCAL_BUS_GRANT);

// File: dv/rsbw_host_model.sv
// remote host model driving the write pins
`timescale 1ns/1ps
module rsbw_host_model (
  input wire logic CLK_SYS,  // system clock
  input wire logic go,  // start one write
  input wire logic cmd,  // config target
  input wire logic [7:0] data,  // byte to write
  input wire logic [3:0] stall,  // wait low cycles
  input wire logic TRANSFER_ACKNOWLEDGE,  // device hold
  input wire logic LOCAL_BUS_OWNER_N,  // host owns buses
  input wire logic AD_OE,  // device drives bus
  output logic REMOTE_ACCESS_ENABLE,  // access enable
  output logic REMOTE_WRITE_STROBE_N,  // write strobe
  output logic COMMAND_SELECT,  // config target
  output logic WAIT_N,  // wait request
  output logic [7:0] AD_IN,  // bus towards device
  output logic done  // write finished
);
  logic [1:0] ph;  // 0 idle, 1 want ack low, 2 want ack high
  logic [3:0] wcnt;  // wait cycles left
  logic [7:0] last;  // byte being written
  initial begin
    ph = 0; wcnt = 0; last = 8'h00; done = 0;
    REMOTE_ACCESS_ENABLE = 0; REMOTE_WRITE_STROBE_N = 1; COMMAND_SELECT = 0; WAIT_N = 1;
  end
  // request, hold, release sequencing
  always @(posedge CLK_SYS) begin
    done <= 1'b0;
    if (ph == 0 && go) begin
      REMOTE_ACCESS_ENABLE <= 1; REMOTE_WRITE_STROBE_N <= 0; COMMAND_SELECT <= cmd;
      last <= data; wcnt <= stall; ph <= 1;
    end else if (ph == 1 && !TRANSFER_ACKNOWLEDGE) begin
      ph <= 2;
    end else if (ph == 2 && TRANSFER_ACKNOWLEDGE) begin
      REMOTE_ACCESS_ENABLE <= 0; REMOTE_WRITE_STROBE_N <= 1; done <= 1; ph <= 0;
    end
    if (LOCAL_BUS_OWNER_N && wcnt != 0) begin
      WAIT_N <= 0; wcnt <= wcnt - 1;
    end else WAIT_N <= 1;
  end
  // host drives bus, released shows inverse
  assign AD_IN = (!AD_OE && !REMOTE_WRITE_STROBE_N) ? last : ~last;
endmodule
